// ==== lts_top.sv ====
// Behaviour
// - pulses under 1 us are dropped
// - strobe pulse starts with each line start
// - trigger off: line starts made internally
// - free run at programmed rate when allowed
// - free run clamped to maximum allowed rate
// - trigger on: one line per qualified event
// - source is external input or CC1
// - rising, falling or both edges selectable
// - line rate follows trigger period
// - rescaler modulates period, else passthrough
// - rescale factor 0.01 to 100
// - averaging filter factor 16 to 512
// - input trigger rate in hertz
// - peak input trigger rate in hertz
// - input trigger jitter in percent
// - input pulse width in microseconds
// - rescaled trigger rate in hertz
// - rescaled trigger jitter in percent
// - direction pin low forward, high reverse
`timescale 1ns/100ps
module lts_top (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ext_trig_i,
  input wire logic cc1_trig_i,
  input wire logic scan_dir_i,
  input wire lts_pkg::lts_cfg_t cfg_i,
  output logic line_start_o,
  output logic strobe_o,
  output logic scan_reverse_o,
  output lts_pkg::lts_stats_t stats_o
);

  typedef struct packed {
    logic src_prev;
    logic q_busy;
    logic q_lvl;
    logic [31:0] q_cnt;
    logic [31:0] width_lat;
    logic [31:0] in_cnt;
    logic [31:0] in_per;
    logic [31:0] in_prev;
    logic [1:0] in_seen;
    logic [lts_pkg::AVG_W-1:0] r_avg;
    logic r_valid;
    logic [lts_pkg::ACC_W-1:0] r_acc;
    logic [31:0] out_cnt;
    logic [31:0] out_per;
    logic [31:0] out_prev;
    logic [1:0] out_seen;
    logic [31:0] fr_cnt;
    logic ls;
    logic [15:0] strb_cnt;
    logic strb;
    logic rev;
    logic div_busy;
    logic [2:0] div_job;
    logic [5:0] div_step;
    logic [31:0] div_num;
    logic [31:0] div_den;
    logic [32:0] div_rem;
    logic [31:0] div_quo;
    lts_pkg::lts_stats_t stats;
  } lts_state_t;

  lts_state_t st_reg;
  lts_state_t st_next;
  logic [2:0] pin_lvl;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  lts_pin_sync #(
    .W(3)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i({scan_dir_i, cc1_trig_i, ext_trig_i}),
    .level_o(pin_lvl)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] abs_dev(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] d;
    d = (a > b) ? (a - b) : (b - a);
    abs_dev = (d > lts_pkg::DEV_SAT) ? lts_pkg::DEV_SAT : d;
  endfunction

  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    sat_inc = (v == 32'hFFFFFFFF) ? v : (v + 32'h00000001);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic src;
  logic edge_hit;
  logic want_lvl;
  logic q_event;
  logic fr_fire;
  logic resc_fire;
  logic line_fire;
  logic [31:0] eff_per;
  logic [lts_pkg::RATE_W-1:0] rate_cl;
  logic [2:0] filt;
  logic signed [lts_pkg::AVG_W:0] avg_diff;
  logic [lts_pkg::ACC_W-1:0] acc_sum;
  logic [lts_pkg::ACC_W-1:0] thr;
  logic [32:0] rem_sh;
  logic [31:0] quo_new;
  logic [31:0] num_sel;
  logic [31:0] den_sel;

  always_comb begin
    st_next = st_reg;
    q_event = 1'b0;
    fr_fire = 1'b0;
    resc_fire = 1'b0;
    num_sel = 32'h00000000;
    den_sel = 32'h00000000;
    rem_sh = 33'h000000000;
    quo_new = 32'h00000000;

    // source select and edge detect
    src = cfg_i.src_cc1 ? pin_lvl[1] : pin_lvl[0];
    st_next.src_prev = src;
    edge_hit = src != st_reg.src_prev;
    case (cfg_i.edge_sel)
      lts_pkg::EDGE_RISE: want_lvl = edge_hit && src;
      lts_pkg::EDGE_FALL: want_lvl = edge_hit && !src;
      default: want_lvl = edge_hit;
    endcase

    // width qualification of the running pulse
    if (st_reg.q_busy) begin
      if (src == st_reg.q_lvl) begin
        st_next.q_cnt = sat_inc(st_reg.q_cnt);
        q_event = st_next.q_cnt == lts_pkg::MIN_WIDTH_CYC;
      end else begin
        st_next.q_busy = 1'b0;
        if (st_reg.q_cnt >= lts_pkg::MIN_WIDTH_CYC) begin
          st_next.width_lat = st_reg.q_cnt;
        end
      end
    end
    if (want_lvl && cfg_i.trig_on) begin
      st_next.q_busy = 1'b1;
      st_next.q_lvl = src;
      st_next.q_cnt = 32'h00000001;
    end
    if (!cfg_i.trig_on) begin
      st_next.q_busy = 1'b0;
    end

    // input period measurement
    st_next.in_cnt = sat_inc(st_reg.in_cnt);
    if (q_event) begin
      st_next.in_cnt = 32'h00000001;
      if (st_reg.in_seen != 2'h0) begin
        st_next.in_prev = st_reg.in_per;
        st_next.in_per = st_reg.in_cnt;
      end
      if (st_reg.in_seen != 2'h3) begin
        st_next.in_seen = st_reg.in_seen + 2'h1;
      end
    end

    // rescaler: averaged period and phase accumulator
    if (cfg_i.resc_rate < lts_pkg::RATE_MIN) begin
      rate_cl = lts_pkg::RATE_MIN;
    end else if (cfg_i.resc_rate > lts_pkg::RATE_MAX) begin
      rate_cl = lts_pkg::RATE_MAX;
    end else begin
      rate_cl = cfg_i.resc_rate;
    end
    filt = (cfg_i.filt_sel > lts_pkg::FILT_SEL_MAX) ? lts_pkg::FILT_SEL_MAX : cfg_i.filt_sel;
    avg_diff = $signed({1'b0, st_reg.in_cnt, {lts_pkg::AVG_FRAC{1'b0}}}) - $signed({1'b0, st_reg.r_avg});
    if (q_event && st_reg.in_seen != 2'h0) begin
      if (!st_reg.r_valid) begin
        st_next.r_avg = {st_reg.in_cnt, {lts_pkg::AVG_FRAC{1'b0}}};
        st_next.r_valid = 1'b1;
      end else begin
        st_next.r_avg = lts_pkg::AVG_W'(st_reg.r_avg
          + lts_pkg::AVG_W'(avg_diff >>> (int'(filt) + lts_pkg::FILT_SHIFT_BASE)));
      end
    end
    thr = {1'b0, st_reg.r_avg, {(lts_pkg::RATE_FRAC - lts_pkg::AVG_FRAC){1'b0}}};
    acc_sum = st_reg.r_acc + lts_pkg::ACC_W'(rate_cl);
    if (cfg_i.trig_on && cfg_i.resc_en && st_reg.r_valid) begin
      if (acc_sum >= thr) begin
        st_next.r_acc = acc_sum - thr;
        resc_fire = 1'b1;
      end else begin
        st_next.r_acc = acc_sum;
      end
    end else begin
      st_next.r_acc = '0;
    end
    if (!cfg_i.trig_on) begin
      st_next.r_valid = 1'b0;
      st_next.in_seen = 2'h0;
    end

    // rescaled period measurement
    st_next.out_cnt = sat_inc(st_reg.out_cnt);
    if (resc_fire) begin
      st_next.out_cnt = 32'h00000001;
      if (st_reg.out_seen != 2'h0) begin
        st_next.out_prev = st_reg.out_per;
        st_next.out_per = st_reg.out_cnt;
      end
      if (st_reg.out_seen != 2'h3) begin
        st_next.out_seen = st_reg.out_seen + 2'h1;
      end
    end

    // free-running line generator
    eff_per = (cfg_i.line_period > cfg_i.min_period) ? cfg_i.line_period : cfg_i.min_period;
    if (cfg_i.trig_on) begin
      st_next.fr_cnt = 32'h00000000;
    end else if (sat_inc(st_reg.fr_cnt) >= eff_per) begin
      st_next.fr_cnt = 32'h00000000;
      fr_fire = 1'b1;
    end else begin
      st_next.fr_cnt = st_reg.fr_cnt + 32'h00000001;
    end

    // line start selection
    if (!cfg_i.trig_on) begin
      line_fire = fr_fire;
    end else if (cfg_i.resc_en) begin
      line_fire = resc_fire;
    end else begin
      line_fire = q_event;
    end
    st_next.ls = line_fire;

    // strobe timed by the line start
    if (line_fire) begin
      st_next.strb_cnt = cfg_i.strobe_width;
    end else if (st_reg.strb_cnt != 16'h0000) begin
      st_next.strb_cnt = st_reg.strb_cnt - 16'h0001;
    end
    st_next.strb = st_next.strb_cnt != 16'h0000;

    // scan direction
    st_next.rev = cfg_i.dir_from_line ? pin_lvl[2] : cfg_i.dir_reverse;

    // statistics divider, one job at a time
    case (st_reg.div_job)
      lts_pkg::JOB_IN_RATE: begin
        num_sel = lts_pkg::CLK_HZ;
        den_sel = st_reg.in_per;
      end
      lts_pkg::JOB_OUT_RATE: begin
        num_sel = lts_pkg::CLK_HZ;
        den_sel = st_reg.out_per;
      end
      lts_pkg::JOB_IN_JIT: begin
        num_sel = 32'(abs_dev(st_reg.in_per, st_reg.in_prev) * lts_pkg::PERCENT);
        den_sel = st_reg.in_prev;
      end
      lts_pkg::JOB_OUT_JIT: begin
        num_sel = 32'(abs_dev(st_reg.out_per, st_reg.out_prev) * lts_pkg::PERCENT);
        den_sel = st_reg.out_prev;
      end
      default: begin
        num_sel = st_reg.width_lat;
        den_sel = lts_pkg::CYC_PER_US;
      end
    endcase

    if (!st_reg.div_busy) begin
      st_next.div_num = num_sel;
      st_next.div_den = den_sel;
      st_next.div_rem = 33'h000000000;
      st_next.div_quo = 32'h00000000;
      st_next.div_step = 6'h00;
      st_next.div_busy = den_sel != 32'h00000000;
      if (den_sel == 32'h00000000) begin
        case (st_reg.div_job)
          lts_pkg::JOB_IN_RATE: st_next.stats.in_trig_rate_stat = 32'h00000000;
          lts_pkg::JOB_OUT_RATE: st_next.stats.out_trig_rate_stat = 32'h00000000;
          lts_pkg::JOB_IN_JIT: st_next.stats.in_trig_jitter_stat = 32'h00000000;
          lts_pkg::JOB_OUT_JIT: st_next.stats.out_trig_jitter_stat = 32'h00000000;
          default: st_next.stats.in_trig_width_stat = 32'h00000000;
        endcase
        st_next.div_job = (st_reg.div_job == lts_pkg::JOB_IN_WIDTH) ? lts_pkg::JOB_IN_RATE
                          : (st_reg.div_job + 3'h1);
      end
    end else begin
      rem_sh = {st_reg.div_rem[31:0], st_reg.div_num[31]};
      if (rem_sh >= {1'b0, st_reg.div_den}) begin
        st_next.div_rem = rem_sh - {1'b0, st_reg.div_den};
        quo_new = {st_reg.div_quo[30:0], 1'b1};
      end else begin
        st_next.div_rem = rem_sh;
        quo_new = {st_reg.div_quo[30:0], 1'b0};
      end
      st_next.div_quo = quo_new;
      st_next.div_num = {st_reg.div_num[30:0], 1'b0};
      st_next.div_step = st_reg.div_step + 6'h01;
      if (st_reg.div_step == lts_pkg::DIV_LAST_STEP) begin
        st_next.div_busy = 1'b0;
        case (st_reg.div_job)
          lts_pkg::JOB_IN_RATE: begin
            st_next.stats.in_trig_rate_stat = quo_new;
            if (quo_new > st_reg.stats.in_trig_peak_rate_stat) begin
              st_next.stats.in_trig_peak_rate_stat = quo_new;
            end
          end
          lts_pkg::JOB_OUT_RATE: st_next.stats.out_trig_rate_stat = quo_new;
          lts_pkg::JOB_IN_JIT: st_next.stats.in_trig_jitter_stat = quo_new;
          lts_pkg::JOB_OUT_JIT: st_next.stats.out_trig_jitter_stat = quo_new;
          default: st_next.stats.in_trig_width_stat = quo_new;
        endcase
        st_next.div_job = (st_reg.div_job == lts_pkg::JOB_IN_WIDTH) ? lts_pkg::JOB_IN_RATE
                          : (st_reg.div_job + 3'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign line_start_o = st_reg.ls;
  assign strobe_o = st_reg.strb;
  assign scan_reverse_o = st_reg.rev;
  assign stats_o = st_reg.stats;

endmodule

// ==== lts_pkg.sv ====
package lts_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_HZ_INT = 1000000000 / CLK_PERIOD_NS;
  localparam logic [31:0] CLK_HZ = 32'(CLK_HZ_INT);
  localparam int MIN_WIDTH_NS = 1000;
  localparam int MIN_WIDTH_CYC_INT = (MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] MIN_WIDTH_CYC = 32'(MIN_WIDTH_CYC_INT);
  localparam int NS_PER_US = 1000;
  localparam logic [31:0] CYC_PER_US = 32'(NS_PER_US / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // activation edge codes
  // ----------------------------------------------------------------
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // ----------------------------------------------------------------
  // rescaler fixed point
  // ----------------------------------------------------------------
  localparam int RATE_W = 23;
  localparam int RATE_FRAC = 16;
  localparam logic [RATE_W-1:0] RATE_MIN = 23'h000290;
  localparam logic [RATE_W-1:0] RATE_MAX = 23'h640000;
  localparam int AVG_FRAC = 9;
  localparam int AVG_W = 32 + AVG_FRAC;
  localparam int ACC_W = 32 + RATE_FRAC + 1;
  localparam logic [2:0] FILT_SEL_MAX = 3'h5;
  localparam int FILT_SHIFT_BASE = 4;

  // ----------------------------------------------------------------
  // statistics
  // ----------------------------------------------------------------
  localparam logic [31:0] PERCENT = 32'h00000064;
  localparam logic [31:0] DEV_SAT = 32'h00FFFFFF;
  localparam logic [2:0] JOB_IN_RATE = 3'h0;
  localparam logic [2:0] JOB_OUT_RATE = 3'h1;
  localparam logic [2:0] JOB_IN_JIT = 3'h2;
  localparam logic [2:0] JOB_OUT_JIT = 3'h3;
  localparam logic [2:0] JOB_IN_WIDTH = 3'h4;
  localparam logic [5:0] DIV_LAST_STEP = 6'h1F;

  typedef struct packed {
    logic trig_on;
    logic src_cc1;
    logic [1:0] edge_sel;
    logic [31:0] line_period;
    logic [31:0] min_period;
    logic resc_en;
    logic [RATE_W-1:0] resc_rate;
    logic [2:0] filt_sel;
    logic [15:0] strobe_width;
    logic dir_from_line;
    logic dir_reverse;
  } lts_cfg_t;

  typedef struct packed {
    logic [31:0] in_trig_rate_stat;
    logic [31:0] in_trig_peak_rate_stat;
    logic [31:0] in_trig_jitter_stat;
    logic [31:0] in_trig_width_stat;
    logic [31:0] out_trig_rate_stat;
    logic [31:0] out_trig_jitter_stat;
  } lts_stats_t;

endpackage

// ==== lts_pin_sync.sv ====
`timescale 1ns/100ps
module lts_pin_sync #(
  parameter int W = 3
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } lts_sync_st_t;

  lts_sync_st_t st_reg;
  lts_sync_st_t st_next;

  // ----------------------------------------------------------------
  // three stages, level moves once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.lvl = (st_reg.s2 & st_reg.s3) | (st_reg.lvl & (st_reg.s2 | st_reg.s3));
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_o = st_reg.lvl;

endmodule

// ==== lts_trig_src_model.sv ====
`timescale 1ns/100ps
module lts_trig_src_model (
  input wire logic core_clk_i,
  output logic ext_trig_o,
  output logic cc1_trig_o
);
  // ----------------------------------------
  // pulse source
  // ----------------------------------------
  logic [1:0] pin = 2'h0;
  assign ext_trig_o = pin[0];
  assign cc1_trig_o = pin[1];

  task automatic hold(input logic sel, input logic lvl, input int cyc);
    pin[sel] <= lvl;
    repeat (cyc) @(posedge core_clk_i);
  endtask

  // idle span keeps events below the maximum line rate
  task automatic pulse(input logic sel, input logic lvl, input int act, input int idle);
    hold(sel, lvl, act);
    hold(sel, !lvl, idle);
  endtask
endmodule

// ==== lts_top_asserts.sv ====
`timescale 1ns/100ps
module lts_top_asserts (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ext_trig_i,
  input wire logic cc1_trig_i,
  input wire logic scan_dir_i,
  input wire lts_pkg::lts_cfg_t cfg_i,
  input wire logic line_start_o,
  input wire logic strobe_o,
  input wire logic scan_reverse_o,
  input wire lts_pkg::lts_stats_t stats_o
);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  lts_pkg::lts_cfg_t cfg_q;
  logic act;
  logic act_q;
  logic tm;
  logic [31:0] hi_reg;
  logic [31:0] gap_reg;
  logic [31:0] age_reg;
  logic [31:0] eff;
  logic [7:0] quiet_reg;

  assign act = (cfg_i.src_cc1 ? cc1_trig_i : ext_trig_i) ^ (cfg_i.edge_sel == lts_pkg::EDGE_FALL);
  assign tm = cfg_i.trig_on && !cfg_i.resc_en && !cfg_i.edge_sel[1] && (age_reg > 32'h2);
  assign eff = (cfg_i.line_period > cfg_i.min_period) ? cfg_i.line_period : cfg_i.min_period;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= '0;
      act_q <= 1'b0;
      hi_reg <= 32'h0;
      gap_reg <= 32'h0;
      age_reg <= 32'h0;
      quiet_reg <= 8'h0;
    end else begin
      cfg_q <= cfg_i;
      act_q <= act;
      hi_reg <= act ? hi_reg + 32'h1 : 32'h0;
      gap_reg <= line_start_o ? 32'h1 : gap_reg + 32'h1;
      age_reg <= (cfg_i == cfg_q) ? age_reg + 32'h1 : 32'h0;
      if (tm && act_q && !act && hi_reg < 32'h5A) begin
        quiet_reg <= 8'hC8;
      end else if (quiet_reg != 8'h0) begin
        quiet_reg <= quiet_reg - 8'h1;
      end
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  strobe_align_a: assert property (line_start_o && cfg_i.strobe_width != 16'h0 |-> strobe_o)
    else $error("strobe low at line start");
  single_pulse_a: assert property (line_start_o && eff > 32'h1 |=> !line_start_o)
    else $error("line start too long");
  free_period_a: assert property (line_start_o && !cfg_i.trig_on && age_reg > gap_reg + 32'h4 |-> gap_reg == eff)
    else $error("free run period wrong");
  trig_lat_a: assert property (tm && $fell(act) && hi_reg >= 32'h82 |-> (hi_reg - gap_reg) inside {[32'h64:32'h6C]})
    else $error("trigger latency wrong");
  short_drop_a: assert property (line_start_o && tm |-> quiet_reg == 8'h0)
    else $error("short pulse started a line");
  trig_only_a: assert property (line_start_o && tm |-> hi_reg >= 32'h64)
    else $error("line start without qualified event");
  dir_line_a: assert property ((cfg_i.dir_from_line && $stable(scan_dir_i)) [*8] |-> scan_reverse_o == scan_dir_i)
    else $error("direction not from pin");
  dir_cfg_a: assert property ((!cfg_i.dir_from_line && $stable(cfg_i)) [*3] |-> scan_reverse_o == cfg_i.dir_reverse)
    else $error("direction not from setting");

  cover property (tm && line_start_o);
  cover property (!cfg_i.trig_on && line_start_o);
  cover property (cfg_i.resc_en && line_start_o);
endmodule

// ==== line_trigger_rescaler_tb.sv ====
`timescale 1ns/100ps
module line_trigger_rescaler_tb;
  logic clk;
  logic rst_n;
  logic dir;
  logic ext;
  logic cc1;
  logic ls;
  logic stb;
  logic rev;
  lts_pkg::lts_cfg_t cfg;
  lts_pkg::lts_stats_t st;
  int error_cnt = 0;
  int checks_done = 0;
  int ls_cnt = 0;
  int stb_len = 0;
  int n;
  int c0;
  logic [31:0] r;

  lts_top u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .ext_trig_i(ext), .cc1_trig_i(cc1), .scan_dir_i(dir),
    .cfg_i(cfg), .line_start_o(ls), .strobe_o(stb), .scan_reverse_o(rev), .stats_o(st));
  lts_trig_src_model u_src (.core_clk_i(clk), .ext_trig_o(ext), .cc1_trig_o(cc1));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] tol = 32'h0);
    checks_done++;
    if (!(got === exp || ((got + tol >= exp) && (got <= exp + tol)) === 1'b1)) begin
      error_cnt++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] fr_period(input logic [31:0] lp, input logic [31:0] mp);
    return (lp > mp) ? lp : mp;
  endfunction

  task automatic wait_ls(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (ls !== 1'b1 && k < 32'h1388);
  endtask

  task automatic results();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (ls === 1'b1) begin
      ls_cnt <= ls_cnt + 1;
    end
    if (stb === 1'b1) begin
      stb_len <= stb_len + 1;
    end else if (stb_len != 0) begin
      chk(32'(stb_len), 32'(cfg.strobe_width));
      stb_len <= 0;
    end
  end

  initial begin
    repeat (32'h15F90) @(posedge clk);
    error_cnt++;
    results();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h4D631E71));
    rst_n = 1'b0;
    dir = 1'b0;
    cfg = '0;
    cfg.line_period = 32'h78;
    cfg.min_period = 32'h50;
    cfg.resc_rate = 23'h010000;
    cfg.strobe_width = 16'($urandom_range(32'h28, 32'h1));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wait_ls(n);
    wait_ls(n);
    chk(32'(n), 32'h78);
    @(posedge clk);
    cfg.trig_on <= 1'b1;
    repeat (5) @(posedge clk);
    c0 = ls_cnt;
    repeat (6) u_src.pulse(1'b0, 1'b1, 32'hFA, 32'h2EE);
    repeat (32'h190) @(posedge clk);
    chk(32'(ls_cnt - c0), 32'h6);
    chk(st.in_trig_rate_stat, lts_pkg::CLK_HZ / 32'h3E8);
    chk(st.in_trig_peak_rate_stat, lts_pkg::CLK_HZ / 32'h3E8);
    chk(st.in_trig_jitter_stat, 32'h0);
    chk(st.in_trig_width_stat, 32'h2);
    for (int s = 0; s < 2; s++) begin
      for (int e = 0; e < 3; e++) begin
        u_src.hold(s[0], e == 1, 32'h12C);
        cfg.src_cc1 <= s[0];
        cfg.edge_sel <= e[1:0];
        repeat (5) @(posedge clk);
        c0 = ls_cnt;
        repeat (3) u_src.pulse(s[0], e != 1, 32'hFA, 32'h2EE);
        u_src.pulse(s[0], e != 1, 32'h3C, 32'h12C);
        u_src.pulse(!s[0], 1'b1, 32'hFA, 32'h12C);
        chk(32'(ls_cnt - c0), (e == 2) ? 32'h7 : 32'h3);
      end
    end
    // one cycle in free run drops the seed left by the mixed edge periods
    cfg.trig_on <= 1'b0;
    cfg.src_cc1 <= 1'b0;
    cfg.edge_sel <= lts_pkg::EDGE_RISE;
    cfg.resc_en <= 1'b1;
    cfg.resc_rate <= 23'h020000;
    cfg.filt_sel <= 3'($urandom_range(32'h7, 32'h0));
    @(posedge clk);
    cfg.trig_on <= 1'b1;
    repeat (4) u_src.pulse(1'b0, 1'b1, 32'hFA, 32'h2EE);
    c0 = ls_cnt;
    repeat (16) u_src.pulse(1'b0, 1'b1, 32'hFA, 32'h2EE);
    chk(32'(ls_cnt - c0), 32'h20, 32'h2);
    chk(st.out_trig_rate_stat, lts_pkg::CLK_HZ / 32'h1F4, 32'hFA0);
    chk(st.out_trig_jitter_stat, 32'h0, 32'h5);
    cfg.trig_on <= 1'b0;
    cfg.resc_en <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      if (i == 0) begin
        r[15:8] = r[7:0];
      end
      @(posedge clk);
      cfg.line_period <= 32'h32 + r[7:0];
      cfg.min_period <= 32'h32 + r[15:8];
      fork
        u_src.pulse(r[16], 1'b1, 32'h96, 32'h64);
        begin
          wait_ls(n);
          wait_ls(n);
          wait_ls(n);
          chk(32'(n), fr_period(32'h32 + r[7:0], 32'h32 + r[15:8]));
        end
      join
    end
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      @(posedge clk);
      cfg.dir_from_line <= r[0];
      cfg.dir_reverse <= r[1];
      dir <= r[2];
      repeat (10) @(posedge clk);
      chk({31'h0, rev}, {31'h0, r[0] ? r[2] : r[1]});
    end
    results();
  end
endmodule

bind lts_top lts_top_asserts u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ext_trig_i(ext_trig_i),
  .cc1_trig_i(cc1_trig_i), .scan_dir_i(scan_dir_i), .cfg_i(cfg_i), .line_start_o(line_start_o),
  .strobe_o(strobe_o), .scan_reverse_o(scan_reverse_o), .stats_o(stats_o));
